// File: bench/timer_pwm_mode_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_mode_control_props (
  input wire logic clk,
  input wire logic nrst,
  input wire timer_pkg::reg_req_type bus_req,
  input wire logic [timer_pkg::DATA_W-1:0] rdata,
  input wire logic global_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  input wire logic external_count_clock_pin,
  input wire logic compare_pin_one,
  input wire logic compare_pin_one_oe,
  input wire logic compare_pin_two,
  input wire logic compare_pin_two_oe,
  input wire logic timer_irq,
  input wire logic wake_request
);
  logic [7:0] c1_r, c2_r, c1_old_r, c2_old_r;
  logic settled, normal;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Shadow controls; writes during halt are dropped like the block does
  always_ff @(posedge clk) begin
    if (!nrst) begin
      c1_r <= 8'h00;
      c2_r <= 8'h00;
    end else if (bus_req.wr && !halt_mode) begin
      if (bus_req.addr == timer_pkg::OFF_CTL_ONE) c1_r <= bus_req.wdata;
      if (bus_req.addr == timer_pkg::OFF_CTL_TWO) c2_r <= bus_req.wdata;
    end
    c1_old_r <= c1_r;
    c2_old_r <= c2_r;
  end
  // Outputs lag a control write by one register stage
  assign settled = c1_r == c1_old_r && c2_r == c2_old_r && !halt_mode;
  assign normal = !c2_r[5] && !c2_r[4];
  sequence rd_of(logic [3:0] a);
    bus_req.rd && bus_req.addr == a ##1 1'b1;
  endsequence
  rd_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  ctl_one_read_a: assert property (rd_of(timer_pkg::OFF_CTL_ONE)
    |-> rdata == $past(c1_r)) else $error("control one readback wrong");
  ctl_two_read_a: assert property (rd_of(timer_pkg::OFF_CTL_TWO)
    |-> rdata == $past(c2_r)) else $error("control two readback wrong");
  unmapped_read_a: assert property (rd_of(4'hf) |-> rdata == 8'h00)
    else $error("unmapped index not read as zero");
  pin_enable_a: assert property (settled |->
    compare_pin_one_oe == c2_r[7] && compare_pin_two_oe == c2_r[6])
    else $error("pin enables do not follow control two");
  force_one_a: assert property (settled && normal && c1_r[3] &&
    c2_r[7] |-> compare_pin_one == c1_r[0])
    else $error("forced level one not on pin one");
  force_two_a: assert property (settled && normal && c1_r[4] &&
    c2_r[6] |-> compare_pin_two == c1_r[2])
    else $error("forced level two not on pin two");
  steady_pwm_a: assert property (settled && c2_r[4] &&
    c1_r[0] == c1_r[2] && compare_pin_one == c1_r[0]
    |=> compare_pin_one == $past(c1_r[0])) else $error("pwm pin toggled");
  irq_enable_a: assert property (settled && c1_r[7:5] == 3'h0
    |-> !timer_irq) else $error("interrupt with all enables off");
  irq_mask_a: assert property (global_mask [*2] |-> !timer_irq)
    else $error("interrupt while masked");
  wake_gate_a: assert property (wake_request |->
    $past(wait_mode) && !$past(halt_mode)) else $error("stray wake request");
endmodule : timer_pwm_mode_control_props
`default_nettype wire

// File: bench/timer_pwm_mode_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); \
  end \
end
module timer_pwm_mode_control_test;
  logic clk, nrst, global_mask, wait_mode, halt_mode, p;
  logic capture_pin_one, capture_pin_two, ext_pin;
  logic pin1, pin1_oe, pin2, pin2_oe, irq, wake;
  logic [7:0] rdata, d, e;
  timer_pkg::reg_req_type bus_req;
  int bad_count, samples_checked, cycles, rises;
  timer_pwm_mode_control dut (.clk(clk), .nrst(nrst), .bus_req(bus_req),
    .rdata(rdata), .global_mask(global_mask), .wait_mode(wait_mode),
    .halt_mode(halt_mode), .capture_pin_one(capture_pin_one),
    .capture_pin_two(capture_pin_two), .external_count_clock_pin(ext_pin),
    .compare_pin_one(pin1), .compare_pin_one_oe(pin1_oe),
    .compare_pin_two(pin2), .compare_pin_two_oe(pin2_oe),
    .timer_irq(irq), .wake_request(wake));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Whole run is about a thousand cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task complete_run();
    $display("Checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic reset_values();
    logic [3:0] ads [0:6] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h7, 4'hf};
    logic [7:0] exps [0:6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80,
      8'h00};
    for (int i = 0; i < 7; i++) begin
      rd(ads[i], d);
      `CHK("reset value", exps[i], d);
    end
    wr(4'h0, 8'ha5);
    rd(4'h0, d);
    `CHK("control one", 8'ha5, d);
    wr(4'h0, 8'h00);
  endtask : reset_values
  task automatic clock_select();
    int divs [0:2] = '{4, 2, 8};
    for (int i = 0; i < 3; i++) begin
      wr(4'h1, {4'h0, 2'(i), 2'h0});
      rd(4'ha, d);
      cyc(62);
      rd(4'ha, e);
      `CHK("ticks per 64", 8'(64 / divs[i]), 8'(e - d));
    end
    // External count, rising then falling edges
    for (int k = 1; k >= 0; k--) begin
      wr(4'h1, 8'h0c | 8'(k));
      rd(4'ha, d);
      repeat (5) begin
        @(posedge clk) ext_pin <= 1'b1;
        cyc(4);
        ext_pin <= 1'b0;
        cyc(4);
      end
      cyc(6);
      rd(4'ha, e);
      `CHK("external ticks", 8'h05, 8'(e - d));
    end
  endtask : clock_select
  task overflow_irq();
    wr(4'h0, 8'h20);
    wr(4'h1, 8'h04);
    wr(4'ha, 8'h00);
    cyc(20);
    rd(4'h2, d);
    `CHK("overflow flag", 8'h20, d);
    `CHK("overflow irq", 1'b1, irq);
    @(posedge clk) wait_mode <= 1'b1;
    cyc(3);
    #1 `CHK("wake", 1'b1, wake);
    @(posedge clk) wait_mode <= 1'b0;
    global_mask <= 1'b1;
    cyc(3);
    #1 `CHK("masked irq", 1'b0, irq);
    @(posedge clk) global_mask <= 1'b0;
    rd(4'h2, d);
    rd(4'hc, d);
    rd(4'h2, d);
    `CHK("alt keeps flag", 8'h20, d);
    rd(4'ha, d);
    rd(4'h2, d);
    `CHK("flag cleared", 8'h00, d);
    cyc(2);
    #1 `CHK("irq cleared", 1'b0, irq);
  endtask : overflow_irq
  task halt_freeze();
    @(posedge clk) halt_mode <= 1'b1;
    cyc(2);
    rd(4'ha, d);
    cyc(30);
    rd(4'ha, e);
    `CHK("frozen count", d, e);
    @(posedge clk) halt_mode <= 1'b0;
    cyc(10);
    rd(4'ha, e);
    `CHK("resumed", 1'b1, e != d);
  endtask : halt_freeze
  task capture_two();
    wr(4'h1, 8'h06);
    @(posedge clk) capture_pin_two <= 1'b1;
    cyc(8);
    rd(4'h2, d);
    `CHK("rising capture", 1'b1, d[4]);
    rd(4'he, d);
    @(posedge clk) capture_pin_two <= 1'b0;
    cyc(8);
    rd(4'h2, d);
    `CHK("falling ignored", 1'b0, d[4]);
  endtask : capture_two
  task force_pins();
    wr(4'h1, 8'hc0);
    wr(4'h0, 8'h1d);
    cyc(2);
    #1 `CHK("forced high", 4'hf, {pin1, pin2, pin1_oe, pin2_oe});
    wr(4'h0, 8'h18);
    wr(4'h1, 8'h00);
    cyc(2);
    #1 `CHK("forced low", 4'h0, {pin1, pin2, pin1_oe, pin2_oe});
  endtask : force_pins
  task pwm_mode();
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h10);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h08);
    wr(4'h0, 8'h84);
    wr(4'h1, 8'hb4);
    wr(4'ha, 8'h00);
    // Period is 21 ticks at divide by 2, so 210 cycles hold five
    capture_pin_one <= 1'b1;
    rises = 0;
    p = pin1;
    repeat (210) begin
      @(posedge clk);
      #1 if (pin1 && !p) rises++;
      p = pin1;
    end
    capture_pin_one <= 1'b0;
    `CHK("pwm cycles", 1'b1, rises >= 4 && rises <= 6);
    rd(4'ha, d);
    `CHK("pwm range", 1'b1, d <= 8'h10 || d >= 8'hfc);
    rd(4'h2, d);
    `CHK("pwm flags", 8'h80, d & 8'hc8);
    `CHK("pwm irq", 1'b1, irq);
    rd(4'h4, d);
    `CHK("pin one ignored", 8'h00, d);
    wr(4'h0, 8'h85);
    cyc(50);
    rises = 0;
    repeat (100) begin
      @(posedge clk);
      #1 if (pin1 !== 1'b1) rises++;
    end
    `CHK("steady pin", 0, rises);
  endtask : pwm_mode
  task compare_inhibit();
    wr(4'h0, 8'h40);
    wr(4'h1, 8'h04);
    wr(4'h5, 8'h00);
    wr(4'ha, 8'h00);
    cyc(20);
    rd(4'h2, d);
    `CHK("inhibited match", 1'b0, d[6]);
    wr(4'h6, 8'h20);
    cyc(80);
    rd(4'h2, d);
    `CHK("match after low byte", 1'b1, d[6]);
    `CHK("compare irq", 1'b1, irq);
    wr(4'h6, 8'h20);
    rd(4'h2, d);
    `CHK("compare flag cleared", 1'b0, d[6]);
  endtask : compare_inhibit
  task halt_capture();
    wr(4'h1, 8'h06);
    @(posedge clk) halt_mode <= 1'b1;
    cyc(3);
    capture_pin_two <= 1'b1;
    cyc(8);
    rd(4'h2, d);
    `CHK("no capture in halt", 1'b0, d[4]);
    rd(4'ha, e);
    @(posedge clk) halt_mode <= 1'b0;
    cyc(4);
    rd(4'h2, d);
    `CHK("capture at wake", 1'b1, d[4]);
    rd(4'he, d);
    `CHK("exit count", e, d);
  endtask : halt_capture
  task one_pulse();
    wr(4'h0, 8'h06);
    wr(4'h1, 8'ha4);
    capture_pin_one <= 1'b1;
    cyc(8);
    #1 `CHK("pulse started", 1'b1, pin1);
    rd(4'h4, d);
    `CHK("pulse capture", 8'hfd, d);
    cyc(40);
    #1 `CHK("pulse ended", 1'b0, pin1);
  endtask : one_pulse
  initial begin
    nrst = 1'b0;
    bus_req = '0;
    global_mask = 1'b0;
    wait_mode = 1'b0;
    halt_mode = 1'b0;
    capture_pin_one = 1'b0;
    capture_pin_two = 1'b0;
    ext_pin = 1'b0;
    cyc(10);
    nrst <= 1'b1;
    reset_values();
    clock_select();
    overflow_irq();
    halt_freeze();
    capture_two();
    force_pins();
    compare_inhibit();
    halt_capture();
    pwm_mode();
    one_pulse();
    complete_run();
  end
endmodule : timer_pwm_mode_control_test
bind timer_pwm_mode_control timer_pwm_mode_control_props props_i (
  .clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
  .global_mask(global_mask), .wait_mode(wait_mode), .halt_mode(halt_mode),
  .capture_pin_one(capture_pin_one), .capture_pin_two(capture_pin_two),
  .external_count_clock_pin(external_count_clock_pin),
  .compare_pin_one(compare_pin_one), .compare_pin_one_oe(compare_pin_one_oe),
  .compare_pin_two(compare_pin_two), .compare_pin_two_oe(compare_pin_two_oe),
  .timer_irq(timer_irq), .wake_request(wake_request));
`default_nettype wire

// File: verilog/timer_pkg.sv
`default_nettype none
package timer_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 16;

  // Register offsets (byte index on the plain register port)
  localparam logic [3:0] OFF_CTL_ONE = 4'h0;
  localparam logic [3:0] OFF_CTL_TWO = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam logic [3:0] OFF_CAP1_HI = 4'h3;
  localparam logic [3:0] OFF_CAP1_LO = 4'h4;
  localparam logic [3:0] OFF_CMP1_HI = 4'h5;
  localparam logic [3:0] OFF_CMP1_LO = 4'h6;
  localparam logic [3:0] OFF_CMP2_HI = 4'h7;
  localparam logic [3:0] OFF_CMP2_LO = 4'h8;
  localparam logic [3:0] OFF_CNT_HI = 4'h9;
  localparam logic [3:0] OFF_CNT_LO = 4'ha;
  localparam logic [3:0] OFF_ALT_HI = 4'hb;
  localparam logic [3:0] OFF_ALT_LO = 4'hc;
  localparam logic [3:0] OFF_CAP2_HI = 4'hd;
  localparam logic [3:0] OFF_CAP2_LO = 4'he;

  // Control one bit positions
  localparam int C1_CAP_IE = 7;
  localparam int C1_CMP_IE = 6;
  localparam int C1_OVF_IE = 5;
  localparam int C1_FORCE2 = 4;
  localparam int C1_FORCE1 = 3;
  localparam int C1_LVL2 = 2;
  localparam int C1_EDGE1 = 1;
  localparam int C1_LVL1 = 0;
  // Control two bit positions
  localparam int C2_PIN_EN1 = 7;
  localparam int C2_PIN_EN2 = 6;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PWM = 4;
  localparam int C2_CLK_HI = 3;
  localparam int C2_CLK_LO = 2;
  localparam int C2_EDGE2 = 1;
  localparam int C2_EXT_EDGE = 0;
  // Status bit positions
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_OVF = 5;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;

  localparam logic [7:0] CTL_ONE_RST = 8'h00;
  localparam logic [7:0] CTL_TWO_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'hfffc;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [15:0] CAP_PULSE_VAL = 16'hfffd;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [15:0] CMP_RST = 16'h8000;

  // Clock select codes
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_type;

  typedef struct packed {
    logic cap1;
    logic cmp1;
    logic ovf;
    logic cap2;
    logic cmp2;
  } flags_type;
endpackage : timer_pkg
`default_nettype wire

// File: verilog/timer_pwm_mode_control.sv
// Functional notes
// R1: In PWM mode a compare-two match reloads the counter with FFFCh.
// R2: Software loads compare value as time times fCPU over prescaler minus 5.
// R3: Equal match levels in PWM mode keep compare pin one constant.
// R4: Writing a compare high byte inhibits that compare until low byte written.
// R5: PWM mode never sets either compare match flag.
// R6: PWM compare-two match sets capture flag one, interrupting if enabled.
// R7: PWM mode ignores capture pin one; capture pin two still captures.
// R8: One-pulse and PWM selects both set gives PWM mode only.
// R9: Wait mode leaves timer running; enabled interrupts request wake.
// R10: Halt freezes counter and registers; resumes from held count.
// R11: Capture edge in halt arms; on wake flag sets, exit count captured.
// R12: One shared interrupt, gated by enables and global mask; no halt exit.
// R13: Capture interrupt enable raises interrupt on either capture flag.
// R14: Compare interrupt enable raises interrupt on either compare flag.
// R15: Overflow interrupt enable raises interrupt on overflow flag.
// R16: Force bits copy match levels to enabled compare pins without compare.
// R17: Level one drives pin one; level two drives pin two, or pin one.
// R18: Capture edge selects: zero falling, one rising.
// R19: Pin enables only route outputs; compare functions keep running.
// R20: One-pulse: pin-one edge fires pulse; PWM: width cmp1, period cmp2.
// R21: Clock select: 00 div4, 01 div2, 10 div8, 11 external.
// R22: External edge select: zero falling, one rising.
// R23: Flags clear after status read then access of matching low byte.
// R24: Counter increments by one per tick, wrapping all-ones to zero.
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_mode_control (
  input wire logic clk,
  input wire logic nrst,
  input wire timer_pkg::reg_req_type bus_req,
  output logic [timer_pkg::DATA_W-1:0] rdata,
  input wire logic global_mask,
  input wire logic wait_mode,
  input wire logic halt_mode,
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  input wire logic external_count_clock_pin,
  output logic compare_pin_one,
  output logic compare_pin_one_oe,
  output logic compare_pin_two,
  output logic compare_pin_two_oe,
  output logic timer_irq,
  output logic wake_request
);

  typedef struct packed {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [15:0] cnt;
    logic [15:0] cmp1;
    logic [15:0] cmp2;
    logic [15:0] cap1;
    logic [15:0] cap2;
    timer_pkg::flags_type flags;
    timer_pkg::flags_type armed;
    logic inh1;
    logic inh2;
    logic out1;
    logic out2;
    logic [2:0] presc;
    timer_pkg::sync_type sy_cap1;
    timer_pkg::sync_type sy_cap2;
    timer_pkg::sync_type sy_ext;
    logic halt_d;
    logic halt_arm1;
    logic halt_arm2;
    logic [7:0] rdata;
    logic irq;
    logic wake;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic pwm;
  logic one_pulse_select;
  logic tick;
  logic edge1;
  logic edge2;
  logic ext_edge;
  logic halt_exit;
  logic match1;
  logic match2;
  logic reload;
  logic clr_cap1;
  logic clr_cmp1;
  logic clr_ovf;
  logic clr_cap2;
  logic clr_cmp2;
  logic irq_src;
  logic acc;
  timer_pkg::flags_type set_ev;

  always_comb begin
    state_nxt = state_r;
    // Gather this cycle's set events; merged back before the clear
    state_nxt.flags = '0;
    acc = bus_req.wr | bus_req.rd;

    pwm = state_r.ctl2[timer_pkg::C2_PWM];
    one_pulse_select = state_r.ctl2[timer_pkg::C2_ONE_PULSE] & ~pwm; // see R8

    // Pin synchronisers; only stage two and three feed edge logic
    state_nxt.sy_cap1 = {capture_pin_one, state_r.sy_cap1.s1,
                         state_r.sy_cap1.s2};
    state_nxt.sy_cap2 = {capture_pin_two, state_r.sy_cap2.s1,
                         state_r.sy_cap2.s2};
    state_nxt.sy_ext = {external_count_clock_pin, state_r.sy_ext.s1,
                        state_r.sy_ext.s2};

    edge1 = state_r.ctl1[timer_pkg::C1_EDGE1] ? // see R18
            (state_r.sy_cap1.s2 & ~state_r.sy_cap1.s3) :
            (~state_r.sy_cap1.s2 & state_r.sy_cap1.s3);
    edge2 = state_r.ctl2[timer_pkg::C2_EDGE2] ? // see R18
            (state_r.sy_cap2.s2 & ~state_r.sy_cap2.s3) :
            (~state_r.sy_cap2.s2 & state_r.sy_cap2.s3);
    ext_edge = state_r.ctl2[timer_pkg::C2_EXT_EDGE] ? // see R22
               (state_r.sy_ext.s2 & ~state_r.sy_ext.s3) :
               (~state_r.sy_ext.s2 & state_r.sy_ext.s3);

    // Prescaler runs free so a select change takes effect at once
    state_nxt.presc = state_r.presc + 3'h1;
    unique case (state_r.ctl2[timer_pkg::C2_CLK_HI:timer_pkg::C2_CLK_LO])
      timer_pkg::CLK_DIV4: tick = &state_r.presc[1:0]; // see R21
      timer_pkg::CLK_DIV2: tick = state_r.presc[0]; // see R21
      timer_pkg::CLK_DIV8: tick = &state_r.presc; // see R21
      timer_pkg::CLK_EXT: tick = ext_edge; // see R21
    endcase
    if (halt_mode) begin
      tick = 1'b0; // see R10
    end

    state_nxt.halt_d = halt_mode;
    halt_exit = state_r.halt_d & ~halt_mode;

    match1 = tick & ~state_r.inh1 & (state_r.cnt == state_r.cmp1);
    match2 = tick & ~state_r.inh2 & (state_r.cnt == state_r.cmp2);
    reload = 1'b0;

    // Counter and compare paths
    if (tick) begin
      state_nxt.cnt = state_r.cnt + 16'h0001; // see R24
      if (state_r.cnt == timer_pkg::CNT_TOP) begin
        state_nxt.flags.ovf = 1'b1;
      end
    end

    if (pwm) begin
      // Compare flags stay untouched here, so no compare interrupt
      if (match1) begin // see R5
        state_nxt.out1 = state_r.ctl1[timer_pkg::C1_LVL1]; // see R20
      end
      if (match2) begin
        reload = 1'b1; // see R1
        state_nxt.out1 = state_r.ctl1[timer_pkg::C1_LVL2]; // see R3
        state_nxt.flags.cap1 = 1'b1; // see R6
      end
    end else if (one_pulse_select) begin
      if (match1) begin
        state_nxt.out1 = state_r.ctl1[timer_pkg::C1_LVL1]; // see R17
      end
      if (match2) begin
        state_nxt.flags.cmp2 = 1'b1;
      end
      if (edge1 & ~halt_mode) begin
        reload = 1'b1; // see R20
        state_nxt.out1 = state_r.ctl1[timer_pkg::C1_LVL2]; // see R17
        state_nxt.flags.cap1 = 1'b1;
        state_nxt.cap1 = timer_pkg::CAP_PULSE_VAL;
      end
    end else begin
      // Match logic runs whatever the pin enables say
      if (match1) begin // see R19
        state_nxt.flags.cmp1 = 1'b1;
        state_nxt.out1 = state_r.ctl1[timer_pkg::C1_LVL1]; // see R17
      end
      if (match2) begin
        state_nxt.flags.cmp2 = 1'b1;
        state_nxt.out2 = state_r.ctl1[timer_pkg::C1_LVL2]; // see R17
      end
      if (state_r.ctl1[timer_pkg::C1_FORCE1]
          & state_r.ctl2[timer_pkg::C2_PIN_EN1]) begin
        state_nxt.out1 = state_r.ctl1[timer_pkg::C1_LVL1]; // see R16
      end
      if (state_r.ctl1[timer_pkg::C1_FORCE2]
          & state_r.ctl2[timer_pkg::C2_PIN_EN2]) begin
        state_nxt.out2 = state_r.ctl1[timer_pkg::C1_LVL2]; // see R16
      end
      if (edge1 & ~halt_mode) begin
        state_nxt.flags.cap1 = 1'b1;
        state_nxt.cap1 = state_r.cnt;
      end
    end
    if (reload) begin
      state_nxt.cnt = timer_pkg::CNT_RELOAD; // see R1
    end

    // Capture two stays live in every mode
    if (edge2 & ~halt_mode) begin // see R7
      state_nxt.flags.cap2 = 1'b1;
      state_nxt.cap2 = state_r.cnt;
    end

    // Halt: edges only arm; flag and capture happen at wake-up
    if (halt_mode) begin
      if (edge1 & ~pwm & ~one_pulse_select) begin
        state_nxt.halt_arm1 = 1'b1; // see R11
      end
      if (edge2) begin
        state_nxt.halt_arm2 = 1'b1; // see R11
      end
    end
    if (halt_exit) begin
      state_nxt.halt_arm1 = 1'b0;
      state_nxt.halt_arm2 = 1'b0;
      if (state_r.halt_arm1) begin
        state_nxt.flags.cap1 = 1'b1; // see R11
        state_nxt.cap1 = state_r.cnt;
      end
      if (state_r.halt_arm2) begin
        state_nxt.flags.cap2 = 1'b1; // see R11
        state_nxt.cap2 = state_r.cnt;
      end
    end

    // Two-step flag clear; a flag set in the same cycle survives
    clr_cap1 = acc & (bus_req.addr == timer_pkg::OFF_CAP1_LO)
               & state_r.armed.cap1;
    clr_cmp1 = acc & (bus_req.addr == timer_pkg::OFF_CMP1_LO)
               & state_r.armed.cmp1;
    clr_ovf = acc & (bus_req.addr == timer_pkg::OFF_CNT_LO)
              & state_r.armed.ovf;
    clr_cap2 = acc & (bus_req.addr == timer_pkg::OFF_CAP2_LO)
               & state_r.armed.cap2;
    clr_cmp2 = acc & (bus_req.addr == timer_pkg::OFF_CMP2_LO)
               & state_r.armed.cmp2;
    // A repeat event on an already set flag must also beat the clear
    set_ev = state_nxt.flags;
    state_nxt.flags = state_r.flags | set_ev;
    if (clr_cap1 & ~set_ev.cap1) begin
      state_nxt.flags.cap1 = 1'b0; // see R23
      state_nxt.armed.cap1 = 1'b0;
    end
    if (clr_cmp1 & ~set_ev.cmp1) begin
      state_nxt.flags.cmp1 = 1'b0; // see R23
      state_nxt.armed.cmp1 = 1'b0;
    end
    if (clr_ovf & ~set_ev.ovf) begin
      state_nxt.flags.ovf = 1'b0; // see R23
      state_nxt.armed.ovf = 1'b0;
    end
    if (clr_cap2 & ~set_ev.cap2) begin
      state_nxt.flags.cap2 = 1'b0; // see R23
      state_nxt.armed.cap2 = 1'b0;
    end
    if (clr_cmp2 & ~set_ev.cmp2) begin
      state_nxt.flags.cmp2 = 1'b0; // see R23
      state_nxt.armed.cmp2 = 1'b0;
    end

    // Register writes; halt freezes the register file
    if (bus_req.wr & ~halt_mode) begin // see R10
      unique case (bus_req.addr)
        timer_pkg::OFF_CTL_ONE: state_nxt.ctl1 = bus_req.wdata;
        timer_pkg::OFF_CTL_TWO: state_nxt.ctl2 = bus_req.wdata;
        timer_pkg::OFF_CMP1_HI: begin
          state_nxt.cmp1[15:8] = bus_req.wdata;
          state_nxt.inh1 = 1'b1; // see R4
        end
        timer_pkg::OFF_CMP1_LO: begin
          state_nxt.cmp1[7:0] = bus_req.wdata;
          state_nxt.inh1 = 1'b0; // see R4
        end
        timer_pkg::OFF_CMP2_HI: begin
          state_nxt.cmp2[15:8] = bus_req.wdata;
          state_nxt.inh2 = 1'b1; // see R4
        end
        timer_pkg::OFF_CMP2_LO: begin
          state_nxt.cmp2[7:0] = bus_req.wdata;
          state_nxt.inh2 = 1'b0; // see R4
        end
        timer_pkg::OFF_CNT_LO, timer_pkg::OFF_ALT_LO: begin
          state_nxt.cnt = timer_pkg::CNT_RST;
        end
        default: ;
      endcase
    end

    // Read data valid in the cycle after the strobe only
    state_nxt.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        timer_pkg::OFF_CTL_ONE: state_nxt.rdata = state_r.ctl1;
        timer_pkg::OFF_CTL_TWO: state_nxt.rdata = state_r.ctl2;
        timer_pkg::OFF_STATUS: begin
          state_nxt.rdata = {state_r.flags, 3'h0};
          state_nxt.armed = state_nxt.armed | state_r.flags; // see R23
        end
        timer_pkg::OFF_CAP1_HI: state_nxt.rdata = state_r.cap1[15:8];
        timer_pkg::OFF_CAP1_LO: state_nxt.rdata = state_r.cap1[7:0];
        timer_pkg::OFF_CMP1_HI: state_nxt.rdata = state_r.cmp1[15:8];
        timer_pkg::OFF_CMP1_LO: state_nxt.rdata = state_r.cmp1[7:0];
        timer_pkg::OFF_CMP2_HI: state_nxt.rdata = state_r.cmp2[15:8];
        timer_pkg::OFF_CMP2_LO: state_nxt.rdata = state_r.cmp2[7:0];
        timer_pkg::OFF_CNT_HI, timer_pkg::OFF_ALT_HI: begin
          state_nxt.rdata = state_r.cnt[15:8];
        end
        timer_pkg::OFF_CNT_LO, timer_pkg::OFF_ALT_LO: begin
          state_nxt.rdata = state_r.cnt[7:0];
        end
        timer_pkg::OFF_CAP2_HI: state_nxt.rdata = state_r.cap2[15:8];
        timer_pkg::OFF_CAP2_LO: state_nxt.rdata = state_r.cap2[7:0];
        default: state_nxt.rdata = 8'h00;
      endcase
    end

    // One shared request, gated by enables and the global mask
    irq_src = (state_r.ctl1[timer_pkg::C1_CAP_IE] & // see R13
               (state_r.flags.cap1 | state_r.flags.cap2))
            | (state_r.ctl1[timer_pkg::C1_CMP_IE] & // see R14
               (state_r.flags.cmp1 | state_r.flags.cmp2))
            | (state_r.ctl1[timer_pkg::C1_OVF_IE] & // see R15
               state_r.flags.ovf);
    state_nxt.irq = irq_src & ~global_mask; // see R12
    // Wake only from wait; halt never exits on a timer event
    state_nxt.wake = irq_src & ~global_mask & wait_mode // see R9
                     & ~halt_mode; // see R12
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= '0;
      state_r.ctl1 <= timer_pkg::CTL_ONE_RST;
      state_r.ctl2 <= timer_pkg::CTL_TWO_RST;
      state_r.cnt <= timer_pkg::CNT_RST; // see R10
      state_r.cmp1 <= timer_pkg::CMP_RST;
      state_r.cmp2 <= timer_pkg::CMP_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rdata = state_r.rdata;
  assign timer_irq = state_r.irq;
  assign wake_request = state_r.wake;
  assign compare_pin_one = state_r.out1;
  assign compare_pin_two = state_r.out2;
  // Enables only route the pin; the match logic never looks at them
  assign compare_pin_one_oe = state_r.ctl2[timer_pkg::C2_PIN_EN1]; // see R19
  assign compare_pin_two_oe = state_r.ctl2[timer_pkg::C2_PIN_EN2]; // see R19

endmodule : timer_pwm_mode_control
`default_nettype wire
